// File: logic/pocu_top.sv
// Power output control: APB registers, fault flags, lamp drivers, four bridges.
// Assumes analog fault comparators and the PWM pin are asynchronous levels.
`timescale 1ns/1ps
// Overview of operation
// - Bridge selects 00 off, 01 low on, 10 high on, 11 high under PWM.
// - In bridge PWM mode the high switch follows the PWM pin.
// - Recirculation bit turns the low switch on while PWM high is off.
// - Reset clears all bridge select bits so every switch starts off.
// - Over-current turns the affected switch off and sets the bridge flag.
// - Writing one clears a bridge flag and re-enables it; zero does nothing.
// - Warning temperature sets its flag; interrupt only when mask bit set.
// - Enabled temperature shutdown turns off lamps and bridge high switches.
// - Temperature flag clears by write one or reset, not while hot.
// - Without shutdown, the higher threshold switches off every power stage.
// - Voltage flags disable bridges and lamps unless inhibit bit set.
// - Voltage flags clear by write one or reset, not while fault persists.
// - Lamps work only while the power stage enable bit is set.
// - Lamp on bit alone keeps it on; both bits clear keep it off.
// - Continuous lamp over-current sets flag, output off until flag cleared.
// - PWM-only lamp follows PWM; over-current cuts it until next rising edge.
// - Both lamp bits: on with inrush limit, flag set, no latch-off.
// - Bridges operate only while the power stage enable bit is set.
// - Never both switches of a bridge on; one waits for the other.
module pocu_top
	import pocu_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_WIDTH-1:0]  paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   pwmIn,
	input  wire logic [NUM_BRIDGES-1:0] bridgeHighOc,
	input  wire logic [NUM_BRIDGES-1:0] bridgeLowOc,
	input  wire logic [NUM_LAMPS-1:0]   lampOc,
	input  wire logic                   tempWarnIn,
	input  wire logic                   tempResetIn,
	input  wire logic                   underVoltIn,
	input  wire logic                   overVoltIn,
	output logic      [NUM_BRIDGES-1:0] bridgeHighOn,
	output logic      [NUM_BRIDGES-1:0] bridgeLowOn,
	output logic      [NUM_LAMPS-1:0]   lampOn,
	output logic                        hvddOn,
	output logic                        auxStagesOff,
	output logic                        tempIrq
);

	typedef struct packed {
		logic [7:0]             system_control_reg;
		logic [7:0]             bridgeOut;
		logic [7:0]             lampOut;
		logic                   recirc;
		logic [NUM_BRIDGES-1:0] bridgeOcf;
		logic [NUM_LAMPS-1:0]   lampOcf;
		logic [NUM_LAMPS-1:0]   lampCut;
		logic                   uvFlag;
		logic                   ovFlag;
		logic                   twFlag;
		logic                   trFlag;
		logic                   twMask;
		logic                   pwmPrev;
		logic [NUM_LAMPS-1:0]   lampOn;
		logic                   hvddOn;
		logic                   auxOff;
		logic                   irq;
		logic                   ready;
		logic                   slverr;
		logic [31:0]            rdata;
	} pocu_state_s;

	pocu_state_s            s_d;
	pocu_state_s            s_q;
	logic [SY_WIDTH-1:0]    syncIn;
	logic                   pwmS;
	logic [NUM_BRIDGES-1:0] ocH;
	logic [NUM_BRIDGES-1:0] ocL;
	logic [NUM_LAMPS-1:0]   ocLamp;
	logic                   twIn;
	logic                   trIn;
	logic                   uvIn;
	logic                   ovIn;
	logic                   wrEn;
	logic                   mapped;
	logic [NUM_BRIDGES-1:0] clrB;
	logic [NUM_LAMPS-1:0]   clrL;
	logic [7:0]             clrI;
	logic                   power_stage_enable;
	logic                   htsEn;
	logic                   voltShut;
	logic                   warnShut;
	logic                   bridgeEn;
	logic                   lampGate;
	logic                   pwmRise;

	// Address decode of one register word
	function automatic logic isReg(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
		return (a[1:0] == 2'b00) && (a[ADDR_WIDTH-1:2] == {2'b00, idx});
	endfunction : isReg

	pocu_sync #(
		.WIDTH (SY_WIDTH)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn ({overVoltIn, underVoltIn, tempResetIn, tempWarnIn,
		           lampOc, bridgeLowOc, bridgeHighOc, pwmIn}),
		.syncOut (syncIn)
	);

	// Synchronised input fields
	assign pwmS   = syncIn[SY_PWM];
	assign ocH    = syncIn[SY_HBH_LSB +: NUM_BRIDGES];
	assign ocL    = syncIn[SY_HBL_LSB +: NUM_BRIDGES];
	assign ocLamp = syncIn[SY_LOC_LSB +: NUM_LAMPS];
	assign twIn   = syncIn[SY_TW];
	assign trIn   = syncIn[SY_TR];
	assign uvIn   = syncIn[SY_UV];
	assign ovIn   = syncIn[SY_OV];

	// Bus write strobe, decode and write-one-to-clear masks
	assign wrEn   = psel & penable & s_q.ready & pwrite;
	assign mapped = isReg(paddr, IDX_SYS_CTRL) | isReg(paddr, IDX_BRIDGE_OUT)
	              | isReg(paddr, IDX_LAMP_OUT) | isReg(paddr, IDX_BRIDGE_STAT)
	              | isReg(paddr, IDX_LAMP_STAT) | isReg(paddr, IDX_IRQ_FLAG)
	              | isReg(paddr, IDX_IRQ_MASK);
	assign clrB   = (wrEn && isReg(paddr, IDX_BRIDGE_STAT)) ?
	                pwdata[BSC_OCF_LSB +: NUM_BRIDGES] : '0;
	assign clrL   = (wrEn && isReg(paddr, IDX_LAMP_STAT)) ?
	                pwdata[LST_OCF_LSB +: NUM_LAMPS] : '0;
	assign clrI   = (wrEn && isReg(paddr, IDX_IRQ_FLAG)) ? pwdata[7:0] : 8'h00;

	// Shutdown conditions from stored flags and control bits
	assign power_stage_enable     = s_q.system_control_reg[SYS_POWER_STAGE_ENABLE_BIT];
	assign htsEn    = |s_q.system_control_reg[SYS_HTS_LSB +: 2];
	assign voltShut = (s_q.uvFlag | s_q.ovFlag) & ~s_q.system_control_reg[SYS_VIS_BIT];
	assign warnShut = s_q.twFlag & htsEn;
	assign bridgeEn = power_stage_enable & ~voltShut & ~s_q.trFlag;
	assign lampGate = power_stage_enable & ~voltShut & ~warnShut & ~s_q.trFlag;
	assign pwmRise  = pwmS & ~s_q.pwmPrev;

	// Next-state logic of registers, flags, lamps and bus answer
	always_comb begin
		s_d         = s_q;
		s_d.pwmPrev = pwmS;
		// APB answers one cycle into the access phase
		s_d.ready   = 1'b0;
		s_d.slverr  = 1'b0;
		s_d.rdata   = '0;
		if (psel && penable && !s_q.ready) begin
			s_d.ready  = 1'b1;
			s_d.slverr = ~mapped;
			if (isReg(paddr, IDX_SYS_CTRL)) begin
				s_d.rdata[7:0] = s_q.system_control_reg;
			end else if (isReg(paddr, IDX_BRIDGE_OUT)) begin
				s_d.rdata[7:0] = s_q.bridgeOut;
			end else if (isReg(paddr, IDX_LAMP_OUT)) begin
				s_d.rdata[7:0] = s_q.lampOut;
			end else if (isReg(paddr, IDX_BRIDGE_STAT)) begin
				s_d.rdata[BSC_RECIRC_BIT]                = s_q.recirc;
				s_d.rdata[BSC_OCF_LSB +: NUM_BRIDGES]    = s_q.bridgeOcf;
			end else if (isReg(paddr, IDX_LAMP_STAT)) begin
				s_d.rdata[LST_OCF_LSB +: NUM_LAMPS]      = s_q.lampOcf;
			end else if (isReg(paddr, IDX_IRQ_FLAG)) begin
				s_d.rdata[IFR_UV_BIT] = s_q.uvFlag;
				s_d.rdata[IFR_OV_BIT] = s_q.ovFlag;
				s_d.rdata[IFR_TW_BIT] = s_q.twFlag;
				s_d.rdata[IFR_TR_BIT] = s_q.trFlag;
			end else if (isReg(paddr, IDX_IRQ_MASK)) begin
				s_d.rdata[IMR_TW_BIT] = s_q.twMask;
			end
		end
		// Plain control register writes
		if (wrEn && isReg(paddr, IDX_SYS_CTRL)) begin
			s_d.system_control_reg = pwdata[7:0];
		end
		if (wrEn && isReg(paddr, IDX_BRIDGE_OUT)) begin
			s_d.bridgeOut = pwdata[7:0];
		end
		if (wrEn && isReg(paddr, IDX_LAMP_OUT)) begin
			s_d.lampOut = pwdata[7:0];
		end
		if (wrEn && isReg(paddr, IDX_BRIDGE_STAT)) begin
			s_d.recirc = pwdata[BSC_RECIRC_BIT];
		end
		if (wrEn && isReg(paddr, IDX_IRQ_MASK)) begin
			s_d.twMask = pwdata[IMR_TW_BIT];
		end
		// Bridge flags, write one clears, set wins
		s_d.bridgeOcf = (s_q.bridgeOcf & ~clrB) | ocH | ocL;
		s_d.lampOcf   = (s_q.lampOcf & ~clrL) | ocLamp;
		// Voltage flags hold while fault present
		s_d.uvFlag    = uvIn | (s_q.uvFlag & ~clrI[IFR_UV_BIT]);
		s_d.ovFlag    = ovIn | (s_q.ovFlag & ~clrI[IFR_OV_BIT]);
		s_d.twFlag    = twIn | (s_q.twFlag & ~clrI[IFR_TW_BIT]);
		s_d.trFlag    = (trIn & ~htsEn) | (s_q.trFlag & ~clrI[IFR_TR_BIT]);
		// Lamp channels
		for (int i = 0; i < NUM_LAMPS; i++) begin
			// Cut until next rising PWM edge
			s_d.lampCut[i] = ocLamp[i] | (s_q.lampCut[i] & ~pwmRise);
			unique case ({s_q.lampOut[LAMP_PWM_LSB + i], s_q.lampOut[LAMP_ON_LSB + i]})
				2'b00: s_d.lampOn[i] = 1'b0;
				2'b01: s_d.lampOn[i] = ~s_q.lampOcf[i] & ~ocLamp[i];
				2'b10: s_d.lampOn[i] = pwmS & ~s_q.lampCut[i] & ~ocLamp[i];
				2'b11: s_d.lampOn[i] = ~s_q.lampCut[i] & ~ocLamp[i];
			endcase
			s_d.lampOn[i] = s_d.lampOn[i] & lampGate;
		end
		s_d.hvddOn = power_stage_enable & s_q.lampOut[LAMP_HVDD_BIT] & ~s_q.trFlag;
		s_d.auxOff = s_q.trFlag;
		s_d.irq    = s_q.twFlag & s_q.twMask;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Half-bridge instances
	for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
		pocu_bridge u_bridge (
			.clk       (clk),
			.sys_rst   (sys_rst),
			.highSel   (s_q.bridgeOut[2*b+1]),
			.lowSel    (s_q.bridgeOut[2*b]),
			.recirc    (s_q.recirc),
			.pwm       (pwmS),
			.enable    (bridgeEn),
			.highBlock (warnShut),
			.ocHigh    (ocH[b]),
			.ocLow     (ocL[b]),
			.ocClear   (clrB[b]),
			.highOn    (bridgeHighOn[b]),
			.lowOn     (bridgeLowOn[b])
		);
	end

	// Registered outputs
	assign prdata       = s_q.rdata;
	assign pready       = s_q.ready;
	assign pslverr      = s_q.slverr;
	assign lampOn       = s_q.lampOn;
	assign hvddOn       = s_q.hvddOn;
	assign auxStagesOff = s_q.auxOff;
	assign tempIrq      = s_q.irq;

	// Checks on the protection behaviour
	property p_bbm;
		@(posedge clk) disable iff (sys_rst) (bridgeHighOn & bridgeLowOn) == '0;
	endproperty
	a_bbm: assert property (p_bbm) else $error("both bridge switches on");

	property p_ocf_set;
		@(posedge clk) disable iff (sys_rst)
		|(ocH | ocL) |=> ((s_q.bridgeOcf & $past(ocH | ocL)) == $past(ocH | ocL));
	endproperty
	a_ocf_set: assert property (p_ocf_set) else $error("bridge flag not set");

	property p_ocf_clr;
		@(posedge clk) disable iff (sys_rst)
		(clrB & ~(ocH | ocL)) != '0 |=> (s_q.bridgeOcf & $past(clrB & ~(ocH | ocL))) == '0;
	endproperty
	a_ocf_clr: assert property (p_ocf_clr) else $error("bridge flag not cleared");

	property p_tw_hold;
		@(posedge clk) disable iff (sys_rst) (clrI[IFR_TW_BIT] && twIn) |=> s_q.twFlag;
	endproperty
	a_tw_hold: assert property (p_tw_hold) else $error("hot flag cleared");

	property p_irq;
		@(posedge clk) disable iff (sys_rst) 1'b1 |=> tempIrq == $past(s_q.twFlag & s_q.twMask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt mismatch");

	property p_volt;
		@(posedge clk) disable iff (sys_rst)
		voltShut |=> (bridgeHighOn == '0 && bridgeLowOn == '0 && lampOn == '0);
	endproperty
	a_volt: assert property (p_volt) else $error("output on in voltage fault");

	property p_power_stage_enable;
		@(posedge clk) disable iff (sys_rst)
		!power_stage_enable |=> (bridgeHighOn == '0 && bridgeLowOn == '0 && lampOn == '0);
	endproperty
	a_power_stage_enable: assert property (p_power_stage_enable) else $error("output on without enable");

	property p_trip_all;
		@(posedge clk) disable iff (sys_rst)
		s_q.trFlag |=> (auxStagesOff && !hvddOn && bridgeHighOn == '0
		 && bridgeLowOn == '0 && lampOn == '0);
	endproperty
	a_trip_all: assert property (p_trip_all) else $error("stage on after hot trip");

	property p_warn;
		@(posedge clk) disable iff (sys_rst) warnShut |=> (bridgeHighOn == '0 && lampOn == '0);
	endproperty
	a_warn: assert property (p_warn) else $error("high side on in shutdown");

	property p_lamp_pwm;
		@(posedge clk) disable iff (sys_rst)
		(s_q.lampOut[LAMP_PWM_LSB + 1] && !s_q.lampOut[LAMP_ON_LSB + 1] && lampGate
		 && !s_q.lampCut[1] && !ocLamp[1]) |=> lampOn[1] == $past(pwmS);
	endproperty
	a_lamp_pwm: assert property (p_lamp_pwm) else $error("lamp not following pwm");

	property p_lamp_on;
		@(posedge clk) disable iff (sys_rst)
		(!s_q.lampOut[LAMP_PWM_LSB] && s_q.lampOut[LAMP_ON_LSB] && lampGate
		 && !s_q.lampOcf[0] && !ocLamp[0]) |=> lampOn[0];
	endproperty
	a_lamp_on: assert property (p_lamp_on) else $error("lamp not on");

	property p_apb;
		@(posedge clk) disable iff (sys_rst) (psel && penable && !pready) |=> pready;
	endproperty
	a_apb: assert property (p_apb) else $error("no bus answer");

	// Main scenarios
	c_bridge_pwm: cover property (@(posedge clk) disable iff (sys_rst)
		bridgeHighOn[0] ##1 !bridgeHighOn[0] ##2 bridgeLowOn[0]);
	c_lamp_reon: cover property (@(posedge clk) disable iff (sys_rst)
		s_q.lampCut[0] ##1 pwmRise ##1 lampOn[0]);
	c_tw_irq: cover property (@(posedge clk) disable iff (sys_rst) tempIrq);
	c_flag_clr: cover property (@(posedge clk) disable iff (sys_rst)
		s_q.bridgeOcf[0] ##1 !s_q.bridgeOcf[0]);

endmodule : pocu_top

// File: logic/pocu_pkg.sv
// Shared constants of the power output control block: register indices,
// field positions, reset values and the layout of the synchronised input vector.
// Assumes a 32-bit APB slave whose register at index N sits at byte address 4*N.
package pocu_pkg;

	localparam int          NUM_BRIDGES    = 4;
	localparam int          NUM_LAMPS      = 3;
	localparam int          ADDR_WIDTH     = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_SYS_CTRL    = 8'h00;
	localparam logic [7:0]  IDX_BRIDGE_OUT  = 8'h01;
	localparam logic [7:0]  IDX_LAMP_OUT    = 8'h02;
	localparam logic [7:0]  IDX_BRIDGE_STAT = 8'h03;
	localparam logic [7:0]  IDX_LAMP_STAT   = 8'h04;
	localparam logic [7:0]  IDX_IRQ_FLAG    = 8'h08;
	localparam logic [7:0]  IDX_IRQ_MASK    = 8'h09;

	// Reset value of every register
	localparam logic [7:0]  REG_RESET      = 8'h00;

	// System control fields
	localparam int          SYS_POWER_STAGE_ENABLE_BIT   = 7;
	localparam int          SYS_VIS_BIT    = 6;
	localparam int          SYS_HTS_LSB    = 0;
	// Bridge status/control fields
	localparam int          BSC_RECIRC_BIT = 7;
	localparam int          BSC_OCF_LSB    = 0;
	// Lamp output and lamp status fields
	localparam int          LAMP_HVDD_BIT  = 7;
	localparam int          LAMP_PWM_LSB   = 3;
	localparam int          LAMP_ON_LSB    = 0;
	localparam int          LST_OCF_LSB    = 0;
	// Interrupt flag and mask fields
	localparam int          IFR_UV_BIT     = 0;
	localparam int          IFR_OV_BIT     = 1;
	localparam int          IFR_TW_BIT     = 2;
	localparam int          IFR_TR_BIT     = 3;
	localparam int          IMR_TW_BIT     = 2;

	// Positions in the synchronised input vector
	localparam int          SY_PWM         = 0;
	localparam int          SY_HBH_LSB     = 1;
	localparam int          SY_HBL_LSB     = 5;
	localparam int          SY_LOC_LSB     = 9;
	localparam int          SY_TW          = 12;
	localparam int          SY_TR          = 13;
	localparam int          SY_UV          = 14;
	localparam int          SY_OV          = 15;
	localparam int          SY_WIDTH       = 16;

endpackage : pocu_pkg

// File: logic/pocu_sync.sv
// Two-flop synchroniser for a vector of independent asynchronous levels.
// Assumes each bit is a slow level; no bus coherence is implied across bits.
`timescale 1ns/1ps
module pocu_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pocu_sync_s;

	pocu_sync_s s_d;
	pocu_sync_s s_q;

	// First stage feeds only the second stage
	always_comb begin
		s_d        = s_q;
		s_d.stage1 = asyncIn;
		s_d.stage2 = s_q.stage1;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign syncOut = s_q.stage2;

endmodule : pocu_sync

// File: logic/pocu_bridge.sv
// One half-bridge: mode decode, PWM and recirculation, trip latches, dead time.
// Assumes all inputs are synchronous to clk; outputs are registered gate commands.
`timescale 1ns/1ps
module pocu_bridge (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic highSel,
	input  wire logic lowSel,
	input  wire logic recirc,
	input  wire logic pwm,
	input  wire logic enable,
	input  wire logic highBlock,
	input  wire logic ocHigh,
	input  wire logic ocLow,
	input  wire logic ocClear,
	output logic      highOn,
	output logic      lowOn
);

	typedef struct packed {
		logic highQ;
		logic lowQ;
		logic tripH;
		logic tripL;
	} pocu_bridge_s;

	pocu_bridge_s s_d;
	pocu_bridge_s s_q;
	logic         wantH;
	logic         wantL;

	always_comb begin
		s_d   = s_q;
		wantH = 1'b0;
		wantL = 1'b0;
		unique case ({highSel, lowSel})
			2'b00: begin
				wantH = 1'b0;
				wantL = 1'b0;
			end
			2'b01: begin
				wantH = 1'b0;
				wantL = 1'b1;
			end
			2'b10: begin
				wantH = 1'b1;
				wantL = 1'b0;
			end
			2'b11: begin
				wantH = pwm;
				wantL = recirc & ~pwm;
			end
		endcase
		// Tripped switch held off; set wins over clear
		s_d.tripH = ocHigh | (s_q.tripH & ~ocClear);
		s_d.tripL = ocLow | (s_q.tripL & ~ocClear);
		// Gating by enable, temperature and trips
		wantH = wantH & enable & ~highBlock & ~s_q.tripH & ~ocHigh;
		wantL = wantL & enable & ~s_q.tripL & ~ocLow;
		s_d.highQ = wantH & ~s_q.lowQ;
		s_d.lowQ  = wantL & ~wantH & ~s_q.highQ;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign highOn = s_q.highQ;
	assign lowOn  = s_q.lowQ;

endmodule : pocu_bridge

// File: tb/pocu_pwm_model.sv
// Stand-in for the controlling processor's PWM pin.
// Assumes run and level come from the bench, synchronous to clk.
`timescale 1ns/1ps
module pocu_pwm_model (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic run,
	input  wire logic level,
	output logic      pwmOut
);
	logic [1:0] phase_q;

	// runs PWM only while run is set
	// Square wave toggling every fourth cycle while running, else a steady level
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_q <= 2'h0;
			pwmOut  <= 1'b0;
		end else if (run) begin
			phase_q <= phase_q + 2'h1;
			if (phase_q == 2'h3) begin
				pwmOut <= ~pwmOut;
			end
		end else begin
			phase_q <= 2'h0;
			pwmOut  <= level;
		end
	end
endmodule : pocu_pwm_model

// File: tb/power_output_control_tb.sv
// Self-checking bench for the power output control block.
// Assumes the block answers APB on its own; the PWM pin comes from the partner model.
`timescale 1ns/1ps
module power_output_control_tb
	import pocu_pkg::*;
;
	localparam logic [13:0] ALL_ON = {3'h2, 3'h7, 4'hC, 4'h2};
	logic                   clk, sys_rst, psel, penable, pwrite, pready, pslverr, sampleReq;
	logic [ADDR_WIDTH-1:0]  paddr;
	logic [31:0]            pwdata, prdata, rnd;
	logic                   pwmIn, pwmRun, pwmLevel, tempWarnIn, tempResetIn;
	logic                   underVoltIn, overVoltIn, hvddOn, auxStagesOff, tempIrq;
	logic [3:0]             bridgeHighOc, bridgeLowOc, bridgeHighOn, bridgeLowOn;
	logic [2:0]             lampOc, lampOn;
	logic [13:0]            outVec;
	logic [32:0]            expQ[$];
	string                  nameQ[$];
	int                     mismatches, checked, cycles;

	pocu_top pocu_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwmIn(pwmIn), .bridgeHighOc(bridgeHighOc),
		.bridgeLowOc(bridgeLowOc), .lampOc(lampOc), .tempWarnIn(tempWarnIn),
		.tempResetIn(tempResetIn), .underVoltIn(underVoltIn), .overVoltIn(overVoltIn),
		.bridgeHighOn(bridgeHighOn), .bridgeLowOn(bridgeLowOn), .lampOn(lampOn),
		.hvddOn(hvddOn), .auxStagesOff(auxStagesOff), .tempIrq(tempIrq));
	pocu_pwm_model pocu_pwm_model_i (.clk(clk), .sys_rst(sys_rst), .run(pwmRun),
		.level(pwmLevel), .pwmOut(pwmIn));

	assign outVec = {auxStagesOff, hvddOn, tempIrq, lampOn, bridgeHighOn, bridgeLowOn};

	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic compare(input string nm, input logic [32:0] exp, input logic [32:0] seen);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : compare

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Monitor: completed reads and requested output samples take the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			compare(nameQ.pop_front(), expQ.pop_front(), {pslverr, prdata});
		if (sampleReq === 1'b1)
			compare(nameQ.pop_front(), expQ.pop_front(), {19'h0, outVec});
	end

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			conclude();
		end
	end

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] d,
			input logic [32:0] exp, input string nm);
		rnd = $urandom;
		if (!wr) begin
			expQ.push_back(exp);
			nameQ.push_back(nm);
		end
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= {rnd[23:0], d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, ADDR_WIDTH'({idx, 2'h0}), d, 33'h0, "");
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		apb(1'b0, ADDR_WIDTH'({idx, 2'h0}), 8'h00, {1'b0, 32'(e)}, nm);
	endtask : rd

	task automatic expectOut(input logic [13:0] e, input string nm);
		expQ.push_back({19'h0, e});
		nameQ.push_back(nm);
		sampleReq <= 1'b1;
		@(posedge clk);
		sampleReq <= 1'b0;
		@(posedge clk);
	endtask : expectOut

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask : settle

	// Main sequence
	initial begin
		logic [7:0] idxs [7];
		idxs = '{IDX_SYS_CTRL, IDX_BRIDGE_OUT, IDX_LAMP_OUT, IDX_BRIDGE_STAT, IDX_LAMP_STAT,
			IDX_IRQ_FLAG, IDX_IRQ_MASK};
		{sys_rst, psel, penable, pwrite, sampleReq, pwmRun, pwmLevel} = 7'h40;
		{tempWarnIn, tempResetIn, underVoltIn, overVoltIn} = 4'h0;
		{bridgeHighOc, bridgeLowOc, lampOc, paddr, pwdata} = '0;
		{mismatches, checked, cycles} = '0;
		rnd = $urandom(6);
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (idxs[i]) rd(idxs[i], 8'h00, "reset value");
		apb(1'b0, 12'h014, 8'h00, {1'b1, 32'h0}, "unmapped read");
		expectOut(14'h0, "outputs after reset");
		$display("test reset done");
		wr(IDX_BRIDGE_OUT, 8'hE4);
		wr(IDX_LAMP_OUT, 8'hB5);
		pwmLevel <= 1'b1;
		settle();
		expectOut(14'h0, "power stage off");
		rd(IDX_BRIDGE_OUT, 8'hE4, "bridge modes");
		wr(IDX_SYS_CTRL, 8'h80);
		settle();
		expectOut(ALL_ON, "modes pwm high");
		pwmLevel <= 1'b0;
		settle();
		expectOut({3'h2, 3'h5, 4'h4, 4'h2}, "modes pwm low");
		wr(IDX_BRIDGE_STAT, 8'h80);
		settle();
		expectOut({3'h2, 3'h5, 4'h4, 4'hA}, "recirculation");
		pwmLevel <= 1'b1;
		settle();
		expectOut(ALL_ON, "recirculation pwm high");
		$display("test modes done");
		bridgeHighOc <= 4'h4;
		settle();
		bridgeHighOc <= 4'h0;
		settle();
		expectOut({3'h2, 3'h7, 4'h8, 4'h2}, "bridge trip");
		rd(IDX_BRIDGE_STAT, 8'h84, "bridge flag");
		wr(IDX_BRIDGE_STAT, 8'h80);
		rd(IDX_BRIDGE_STAT, 8'h84, "flag after zero");
		wr(IDX_BRIDGE_STAT, 8'h04);
		settle();
		expectOut(ALL_ON, "bridge restored");
		lampOc <= 3'h1;
		settle();
		lampOc <= 3'h0;
		settle();
		expectOut({3'h2, 3'h6, 4'hC, 4'h2}, "lamp trip");
		rd(IDX_LAMP_STAT, 8'h01, "lamp flag");
		lampOc <= 3'h2;
		settle();
		lampOc <= 3'h0;
		settle();
		expectOut({3'h2, 3'h4, 4'hC, 4'h2}, "pwm lamp trip");
		wr(IDX_LAMP_STAT, 8'h03);
		pwmLevel <= 1'b0;
		settle();
		pwmLevel <= 1'b1;
		settle();
		expectOut(ALL_ON, "lamps restored");
		pwmRun <= 1'b1;
		lampOc <= 3'h4;
		repeat (20) @(posedge clk);
		lampOc <= 3'h0;
		pwmRun <= 1'b0;
		settle();
		expectOut(ALL_ON, "inrush lamp on");
		rd(IDX_LAMP_STAT, 8'h04, "inrush flag");
		wr(IDX_LAMP_STAT, 8'h04);
		$display("test overcurrent done");
		tempWarnIn <= 1'b1;
		settle();
		expectOut(ALL_ON, "warning masked");
		rd(IDX_IRQ_FLAG, 8'h04, "warning flag");
		wr(IDX_IRQ_MASK, 8'h04);
		wr(IDX_SYS_CTRL, 8'h81);
		settle();
		expectOut({3'h3, 3'h0, 4'h0, 4'h2}, "warning shutdown");
		wr(IDX_IRQ_FLAG, 8'h04);
		rd(IDX_IRQ_FLAG, 8'h04, "clear while hot");
		tempWarnIn <= 1'b0;
		settle();
		expectOut({3'h3, 3'h0, 4'h0, 4'h2}, "cooled still off");
		wr(IDX_IRQ_FLAG, 8'h04);
		wr(IDX_SYS_CTRL, 8'h80);
		settle();
		expectOut(ALL_ON, "warning cleared");
		tempResetIn <= 1'b1;
		settle();
		tempResetIn <= 1'b0;
		settle();
		expectOut({3'h4, 3'h0, 4'h0, 4'h0}, "hot trip");
		rd(IDX_IRQ_FLAG, 8'h08, "hot flag");
		wr(IDX_IRQ_FLAG, 8'h08);
		$display("test temperature done");
		underVoltIn <= 1'b1;
		settle();
		underVoltIn <= 1'b0;
		settle();
		expectOut({3'h2, 3'h0, 4'h0, 4'h0}, "undervoltage off");
		rd(IDX_IRQ_FLAG, 8'h01, "undervoltage flag");
		wr(IDX_SYS_CTRL, 8'hC0);
		settle();
		expectOut(ALL_ON, "inhibit set");
		wr(IDX_SYS_CTRL, 8'h80);
		overVoltIn <= 1'b1;
		settle();
		wr(IDX_IRQ_FLAG, 8'h03);
		rd(IDX_IRQ_FLAG, 8'h02, "clear while over");
		overVoltIn <= 1'b0;
		settle();
		wr(IDX_IRQ_FLAG, 8'h02);
		settle();
		expectOut(ALL_ON, "voltage cleared");
		$display("test voltage done");
		bridgeLowOc <= 4'h2;
		settle();
		bridgeLowOc <= 4'h0;
		settle();
		expectOut({3'h2, 3'h7, 4'hC, 4'h0}, "low switch trip");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(IDX_BRIDGE_STAT, 8'h00, "flag after reset");
		expectOut(14'h0, "outputs after reset");
		$display("test second reset done");
		conclude();
	end
endmodule : power_output_control_tb
